// ### include/fdfr_pkg.sv
// Purpose: Shared constants for the fan floor and local ramp block
// Assumes: APB register access, 50 MHz pclk
// Notes:   Register byte address is four times the register index
package fdfr_pkg;
    // Register indices; byte address = index * 4
    localparam logic [7:0]  IDX_LOCK_CFG   = 8'h40;
    localparam logic [7:0]  IDX_SPEED_CFG  = 8'h10;
    localparam logic [7:0]  IDX_FLOOR_CFG  = 8'h62;
    localparam logic [7:0]  IDX_RAMP_CFG   = 8'h63;
    localparam int          ADDR_LSB       = 2;
    localparam int          ADDR_W         = 12;

    // Field positions
    localparam int          LOCK_BIT       = 1;
    localparam int          SLOW_BIT       = 7;
    localparam int          SYNC_BIT       = 4;
    localparam int          FLOOR1_BIT     = 5;
    localparam int          FLOOR2_BIT     = 6;
    localparam int          FLOOR3_BIT     = 7;
    localparam int          RATE_LSB       = 0;
    localparam int          RATE_W         = 3;

    // Reset values
    localparam logic [7:0]  LOCK_RST       = 8'h00;
    localparam logic [7:0]  SPEED_RST      = 8'h00;
    localparam logic [7:0]  FLOOR_RST      = 8'h00;
    localparam logic [7:0]  RAMP_RST       = 8'h00;
    localparam logic [7:0]  DUTY_ZERO      = 8'h00;
    localparam logic [7:0]  DUTY_FULL      = 8'hFF;

    // Ramp timing: full scale time at one increment per slot
    localparam longint      CLK_HZ         = 50000000;
    localparam longint      FULL_SCALE_MS  = 37500;
    localparam longint      FULL_SLOW_MS   = 52200;
    localparam longint      FULL_STEPS     = 255;
    localparam longint      SLOT_CYC       = (FULL_SCALE_MS * CLK_HZ) / (1000 * FULL_STEPS);
    localparam longint      SLOT_SLOW_CYC  = (FULL_SLOW_MS * CLK_HZ) / (1000 * FULL_STEPS);
    localparam int          SLOT_W         = 24;

    typedef logic [7:0] fdfr_duty_t;

    // Increment per slot for each rate code
    function automatic fdfr_duty_t fdfr_step(input logic [RATE_W-1:0] code);
        fdfr_duty_t s;
        s = 8'h01;
        case (code)
            3'h0:    s = 8'h01;
            3'h1:    s = 8'h02;
            3'h2:    s = 8'h03;
            3'h3:    s = 8'h04;
            3'h4:    s = 8'h08;
            3'h5:    s = 8'h0C;
            3'h6:    s = 8'h18;
            default: s = 8'h30;
        endcase
        return s;
    endfunction
endpackage

// ### rtl/fdfr_core.sv
// Purpose: Fan floor select, tach sync select and local ramp limiter
// Assumes: Auto-mode and threshold inputs come from logic on pclk
// Notes:   PWM outputs are 8-bit, period 255 pclk cycles
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps

// Summary of operation
// - Sync bit picks tach 2-4 or 3-4
// - Fan 1 floor: off or minimum duty
// - Fan 2 floor: off or minimum duty
// - Fan 3 floor: off or minimum duty
// - Lock makes config registers read-only
// - Ramp register resets to zero
// - Bits 2:0 set local ramp rate
// - Ramp duty steps, never jumps, to new target; floor mode switches fan duty at once
// - Rate codes give 1,2,3,4,8,12,24,48 increments
module fdfr_core #(
    parameter int SLOT_CYCLES      = int'(fdfr_pkg::SLOT_CYC),
    parameter int SLOT_SLOW_CYCLES = int'(fdfr_pkg::SLOT_SLOW_CYC)
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [fdfr_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [2:0]                fan_auto_mode,
    input  wire logic [2:0]                below_start_hyst,
    input  wire fdfr_pkg::fdfr_duty_t      fan_min_duty_1,
    input  wire fdfr_pkg::fdfr_duty_t      fan_min_duty_2,
    input  wire fdfr_pkg::fdfr_duty_t      fan_min_duty_3,
    input  wire fdfr_pkg::fdfr_duty_t      local_target_duty,
    output logic [2:0]                     speed_sense_sync,
    output fdfr_pkg::fdfr_duty_t           fan_duty_1,
    output fdfr_pkg::fdfr_duty_t           fan_duty_2,
    output fdfr_pkg::fdfr_duty_t           fan_duty_3,
    output logic                           fan_drive_1,
    output logic                           fan_drive_2,
    output logic                           fan_drive_3
);
    import fdfr_pkg::*;

    logic [7:0]         lock_reg,  lock_next;
    logic [7:0]         speed_reg, speed_next;
    logic [7:0]         floor_reg, floor_next;
    logic [7:0]         ramp_reg,  ramp_next;
    logic [31:0]        rdata_reg, rdata_next;
    logic               err_reg,   err_next;
    logic [SLOT_W-1:0]  slot_reg,  slot_next;
    fdfr_duty_t         duty_reg,  duty_next;
    fdfr_duty_t         fan_reg [3];
    fdfr_duty_t         fan_next [3];
    fdfr_duty_t         pwm_reg,   pwm_next;
    logic [2:0]         drv_reg,   drv_next;

    logic               setup;
    logic               wr;
    logic [7:0]         idx;
    logic               mapped;
    logic               locked;
    logic               tick;
    logic [SLOT_W-1:0]  slot_last;
    fdfr_duty_t         step;
    fdfr_duty_t         gap;
    fdfr_duty_t         min_duty [3];
    logic [2:0]         floor_sel;

    assign idx    = paddr[ADDR_LSB +: 8];
    assign setup  = psel && !penable;
    assign wr     = psel && penable && pwrite;
    assign locked = lock_reg[LOCK_BIT];
    assign mapped = (paddr[ADDR_W-1:ADDR_LSB+8] == '0) && (paddr[ADDR_LSB-1:0] == '0)
                    && (idx == IDX_LOCK_CFG || idx == IDX_SPEED_CFG
                        || idx == IDX_FLOOR_CFG || idx == IDX_RAMP_CFG);

    // Answer is prepared in setup so access completes in one cycle
    assign pready  = 1'b1;
    assign prdata  = rdata_reg;
    assign pslverr = err_reg;

    // Register file
    always_comb
    begin
        lock_next  = lock_reg;
        speed_next = speed_reg;
        floor_next = floor_reg;
        ramp_next  = ramp_reg;
        rdata_next = rdata_reg;
        err_next   = err_reg;
        if (setup)
        begin
            err_next   = !mapped;
            rdata_next = 32'h0000_0000;
            if (mapped && !pwrite)
            begin
                case (idx)
                    IDX_LOCK_CFG:  rdata_next = {24'h00_0000, lock_reg};
                    IDX_SPEED_CFG: rdata_next = {24'h00_0000, speed_reg};
                    IDX_FLOOR_CFG: rdata_next = {24'h00_0000, floor_reg};
                    IDX_RAMP_CFG:  rdata_next = {24'h00_0000, ramp_reg};
                    default:       rdata_next = 32'h0000_0000;
                endcase
            end
        end
        if (wr && mapped)
        begin
            case (idx)
                // Lock is sticky; only reset clears it
                IDX_LOCK_CFG:  lock_next[LOCK_BIT] = lock_reg[LOCK_BIT] | pwdata[LOCK_BIT];
                IDX_SPEED_CFG: if (!locked) speed_next = pwdata[7:0];
                IDX_FLOOR_CFG: if (!locked) floor_next = pwdata[7:0];
                IDX_RAMP_CFG:  if (!locked) ramp_next = pwdata[7:0];
                default:       lock_next = lock_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_reg  <= LOCK_RST;
            speed_reg <= SPEED_RST;
            floor_reg <= FLOOR_RST;
            ramp_reg  <= RAMP_RST;
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
        end
        else
        begin
            lock_reg  <= lock_next;
            speed_reg <= speed_next;
            floor_reg <= floor_next;
            ramp_reg  <= ramp_next;
            rdata_reg <= rdata_next;
            err_reg   <= err_next;
        end
    end

    // Tach 3 and 4 always follow drive 3; tach 2 only when selected
    assign speed_sense_sync = {1'b1, 1'b1, floor_reg[SYNC_BIT]};

    // Local ramp limiter
    assign slot_last = speed_reg[SLOW_BIT] ? SLOT_W'(SLOT_SLOW_CYCLES - 1) : SLOT_W'(SLOT_CYCLES - 1);
    assign tick      = (slot_reg >= slot_last);
    assign step      = fdfr_step(ramp_reg[RATE_LSB +: RATE_W]);
    assign gap       = (local_target_duty > duty_reg) ? local_target_duty - duty_reg
                                                      : duty_reg - local_target_duty;

    always_comb
    begin
        slot_next = tick ? '0 : slot_reg + 1'b1;
        duty_next = duty_reg;
        // Clamp at target so the last step never overshoots
        if (tick && gap != DUTY_ZERO)
        begin
            if (gap <= step)
                duty_next = local_target_duty;
            else if (local_target_duty > duty_reg)
                duty_next = duty_reg + step;
            else
                duty_next = duty_reg - step;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_reg <= '0;
            duty_reg <= DUTY_ZERO;
        end
        else
        begin
            slot_reg <= slot_next;
            duty_reg <= duty_next;
        end
    end

    // Per-fan floor and PWM
    assign min_duty[0] = fan_min_duty_1;
    assign min_duty[1] = fan_min_duty_2;
    assign min_duty[2] = fan_min_duty_3;
    assign floor_sel   = {floor_reg[FLOOR3_BIT], floor_reg[FLOOR2_BIT], floor_reg[FLOOR1_BIT]};
    assign pwm_next    = (pwm_reg == DUTY_FULL - 1'b1) ? DUTY_ZERO : pwm_reg + 1'b1;

    for (genvar g = 0; g < 3; g++)
    begin : g_fan
        always_comb
        begin
            fan_next[g] = duty_reg;
            if (fan_auto_mode[g] && below_start_hyst[g])
                fan_next[g] = floor_sel[g] ? min_duty[g] : DUTY_ZERO;
            drv_next[g] = (pwm_reg < fan_reg[g]);
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                fan_reg[g] <= DUTY_ZERO;
                drv_reg[g] <= 1'b0;
            end
            else
            begin
                fan_reg[g] <= fan_next[g];
                drv_reg[g] <= drv_next[g];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwm_reg <= DUTY_ZERO;
        else
            pwm_reg <= pwm_next;
    end

    assign fan_duty_1  = fan_reg[0];
    assign fan_duty_2  = fan_reg[1];
    assign fan_duty_3  = fan_reg[2];
    assign fan_drive_1 = drv_reg[0];
    assign fan_drive_2 = drv_reg[1];
    assign fan_drive_3 = drv_reg[2];

    // Checks
    sequence s_locked_write(logic [7:0] i);
        locked && wr && idx == i && mapped;
    endsequence

    sequence s_open_write(logic [7:0] i);
        !locked && wr && idx == i && mapped;
    endsequence

    property p_lock_holds;
        @(posedge pclk) disable iff (!presetn)
        s_locked_write(IDX_RAMP_CFG) or s_locked_write(IDX_FLOOR_CFG) |=> $stable(ramp_reg) && $stable(floor_reg);
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("write changed locked register");

    property p_sync_sel;
        @(posedge pclk) disable iff (!presetn)
        s_open_write(IDX_FLOOR_CFG) |=> speed_sense_sync == {2'b11, $past(pwdata[SYNC_BIT])};
    endproperty
    a_sync_sel: assert property (p_sync_sel) else $error("tach sync select wrong");

    property p_floor(int g, logic fsel, fdfr_duty_t md, fdfr_duty_t q);
        @(posedge pclk) disable iff (!presetn)
        fan_auto_mode[g] && below_start_hyst[g] |=> q == ($past(fsel) ? $past(md) : DUTY_ZERO);
    endproperty
    a_floor1: assert property (p_floor(0, floor_reg[FLOOR1_BIT], fan_min_duty_1, fan_duty_1))
        else $error("fan 1 floor wrong");
    a_floor2: assert property (p_floor(1, floor_reg[FLOOR2_BIT], fan_min_duty_2, fan_duty_2))
        else $error("fan 2 floor wrong");
    a_floor3: assert property (p_floor(2, floor_reg[FLOOR3_BIT], fan_min_duty_3, fan_duty_3))
        else $error("fan 3 floor wrong");

    property p_reset_zero;
        @(posedge pclk) $rose(presetn) |-> ramp_reg == RAMP_RST && duty_reg == DUTY_ZERO;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("ramp register not zero after reset");

    property p_no_jump;
        @(posedge pclk) disable iff (!presetn)
        !tick |=> $stable(duty_reg);
    endproperty
    a_no_jump: assert property (p_no_jump) else $error("duty moved between slots");

    property p_rate_one;
        @(posedge pclk) disable iff (!presetn)
        tick && ramp_reg[2:0] == 3'h0 && local_target_duty > duty_reg |=> duty_reg == $past(duty_reg) + 8'h01;
    endproperty
    a_rate_one: assert property (p_rate_one) else $error("code 000 step not one");

    property p_rate_four;
        @(posedge pclk) disable iff (!presetn)
        tick && ramp_reg[2:0] == 3'h3 && local_target_duty > duty_reg + 8'h04 && duty_reg < 8'hF0
        |=> duty_reg == $past(duty_reg) + 8'h04;
    endproperty
    a_rate_four: assert property (p_rate_four) else $error("code 011 step not four");

    property p_stop_at_target;
        @(posedge pclk) disable iff (!presetn)
        tick && gap != DUTY_ZERO && gap <= step |=> duty_reg == $past(local_target_duty);
    endproperty
    a_stop_at_target: assert property (p_stop_at_target) else $error("ramp overshot target");

    // Lock survives every write until reset
    property p_lock_sticky;
        @(posedge pclk) disable iff (!presetn)
        locked |=> locked;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared without reset");

    property p_speed_locked;
        @(posedge pclk) disable iff (!presetn)
        s_locked_write(IDX_SPEED_CFG) |=> $stable(speed_reg);
    endproperty
    a_speed_locked: assert property (p_speed_locked) else $error("write changed locked speed register");

    // Unmapped word answers with error and zero data
    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        setup && !mapped |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    // Slot counter restarts after each step
    property p_slot_wrap;
        @(posedge pclk) disable iff (!presetn)
        tick |=> slot_reg == '0;
    endproperty
    a_slot_wrap: assert property (p_slot_wrap) else $error("slot counter did not restart");

    property p_rate_three_down;
        @(posedge pclk) disable iff (!presetn)
        tick && ramp_reg[2:0] == 3'h2 && duty_reg > local_target_duty + 8'h03 && local_target_duty < 8'hF0
        |=> duty_reg == $past(duty_reg) - 8'h03;
    endproperty
    a_rate_three_down: assert property (p_rate_three_down) else $error("code 010 step not three");

    property p_rate_big;
        @(posedge pclk) disable iff (!presetn)
        tick && ramp_reg[2:0] == 3'h7 && local_target_duty > duty_reg + 8'h30 && duty_reg < 8'hC0
        |=> duty_reg == $past(duty_reg) + 8'h30;
    endproperty
    a_rate_big: assert property (p_rate_big) else $error("code 111 step not 48");

    // Zero duty must keep the drive pin low for the whole period
    property p_drive_off(fdfr_duty_t q, logic drv);
        @(posedge pclk) disable iff (!presetn)
        q == DUTY_ZERO |=> !drv;
    endproperty
    a_drive_off1: assert property (p_drive_off(fan_duty_1, fan_drive_1))
        else $error("fan 1 driven at zero duty");
    a_drive_off2: assert property (p_drive_off(fan_duty_2, fan_drive_2))
        else $error("fan 2 driven at zero duty");
    a_drive_off3: assert property (p_drive_off(fan_duty_3, fan_drive_3))
        else $error("fan 3 driven at zero duty");

endmodule // fdfr_core

// ### verif/fdfr_fan_model.sv
// Purpose: Fan stand-in that measures the duty seen on one drive pin
// Assumes: Drive period of 255 pclk cycles
// Notes:   Window is free running, so a duty is exact only once steady
`timescale 1ns/10ps
module fdfr_fan_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       drive,
    output logic      [7:0] duty_seen
);
    logic [7:0] win_reg;
    logic [7:0] win_next;
    logic [7:0] hi_reg;
    logic [7:0] hi_next;
    logic [7:0] seen_next;
    logic       wrap;

    always_comb
    begin
        wrap      = (win_reg == 8'hFE);
        win_next  = wrap ? 8'h00 : win_reg + 8'h01;
        hi_next   = wrap ? 8'h00 : hi_reg + {7'h00, drive};
        seen_next = wrap ? hi_reg + {7'h00, drive} : duty_seen;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            win_reg   <= 8'h00;
            hi_reg    <= 8'h00;
            duty_seen <= 8'h00;
        end
        else
        begin
            win_reg   <= win_next;
            hi_reg    <= hi_next;
            duty_seen <= seen_next;
        end
    end
endmodule // fdfr_fan_model

// ### verif/fdfr_core_tb.sv
// Purpose: Self-checking bench for floor, sync, ramp and lock behaviour
// Assumes: Short slots of 8 and 11 cycles
// Notes:   Duty outputs are sampled on the falling edge, APB read data on the rising edge
`timescale 1ns/10ps
module fdfr_core_tb;
    import fdfr_pkg::*;
    localparam int SLOT = 8;
    localparam int SLOW = 11;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] auto_m, below, sync;
    logic [7:0] fan1_floor_select, fan2_floor_select, fan3_floor_select, tgt, d1, d2, d3, seen;
    logic [7:0] seen2, seen3;
    logic dr1, dr2, dr3, err;
    int errors = 0, check_count = 0, cyc = 0;
    logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};

    fdfr_core #(.SLOT_CYCLES(SLOT), .SLOT_SLOW_CYCLES(SLOW)) u_fdfr_core (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fan_auto_mode(auto_m), .below_start_hyst(below),
        .fan_min_duty_1(fan1_floor_select), .fan_min_duty_2(fan2_floor_select), .fan_min_duty_3(fan3_floor_select), .local_target_duty(tgt),
        .speed_sense_sync(sync), .fan_duty_1(d1), .fan_duty_2(d2), .fan_duty_3(d3),
        .fan_drive_1(dr1), .fan_drive_2(dr2), .fan_drive_3(dr3));
    fdfr_fan_model u_fdfr_fan_model (.pclk(pclk), .presetn(presetn), .drive(dr1), .duty_seen(seen));
    fdfr_fan_model u_fdfr_fan_model_2 (.pclk(pclk), .presetn(presetn), .drive(dr2), .duty_seen(seen2));
    fdfr_fan_model u_fdfr_fan_model_3 (.pclk(pclk), .presetn(presetn), .drive(dr3), .duty_seen(seen3));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic floor_sync(input logic [2:0] f, input logic s);
        apb(1'b1, 12'h188, {f, s, 4'h0});
        repeat (3) @(negedge pclk);
        chk("sync", {2'b11, s}, sync);
        chk("duty1", f[0] ? fan1_floor_select : 8'h00, d1);
        chk("duty2", f[1] ? fan2_floor_select : 8'h00, d2);
        chk("duty3", f[2] ? fan3_floor_select : 8'h00, d3);
    endtask

    task automatic ramp(input logic [2:0] code, input logic [7:0] t, input int slot);
        logic [7:0] prev, st, e;
        int n, k;
        st = steps[code];
        apb(1'b1, 12'h18C, {5'h00, code});
        tgt <= t;
        @(negedge pclk);
        prev = d1;
        k = 0;
        while (prev !== t && k < 40)
        begin
            n = 0;
            do begin @(negedge pclk); n++; end while (d1 === prev && n < 100);
            e = (prev < t) ? ((t - prev > st) ? prev + st : t) : ((prev - t > st) ? prev - st : t);
            chk("ramp step", e, d1);
            if (k > 0) chk("slot gap", slot, n);
            prev = d1;
            k++;
        end
        repeat (3 * slot) @(negedge pclk);
        chk("ramp hold", t, d1);
    endtask

    task automatic reset_check();
        apb(1'b0, 12'h18C, 8'h00);
        chk("ramp reset", 32'h0, rd);
        apb(1'b0, 12'h188, 8'h00);
        chk("floor reset", 32'h0, rd);
        chk("sync reset", 3'b110, sync);
    endtask

    // Pins measured over whole periods by the fan stand-ins
    task automatic fan_seen();
        repeat (600) @(negedge pclk);
        chk("fan1 seen", fan1_floor_select, seen);
        chk("fan2 seen", 8'h00, seen2);
        chk("fan3 seen", fan3_floor_select, seen3);
    endtask

    // Above the floor threshold every fan follows the ramp again
    task automatic floor_release(input logic [7:0] t);
        @(posedge pclk);
        below <= 3'b000;
        repeat (3) @(negedge pclk);
        chk("free duty1", t, d1);
        chk("free duty2", t, d2);
        chk("free duty3", t, d3);
    endtask

    task automatic unmapped_check();
        apb(1'b0, 12'h004, 8'h00);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
    endtask

    task automatic lock_check();
        apb(1'b1, 12'h100, 8'h02);
        apb(1'b1, 12'h18C, 8'h05);
        apb(1'b1, 12'h188, 8'h00);
        apb(1'b1, 12'h040, 8'h00);
        apb(1'b1, 12'h100, 8'h00);
        apb(1'b0, 12'h18C, 8'h00);
        chk("locked ramp", 32'h6, rd);
        apb(1'b0, 12'h188, 8'h00);
        chk("locked floor", 32'hB0, rd);
        apb(1'b0, 12'h040, 8'h00);
        chk("locked speed", 32'h80, rd);
        apb(1'b0, 12'h100, 8'h00);
        chk("lock sticky", 32'h2, rd);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        auto_m  = 3'b000;
        below   = 3'b000;
        fan1_floor_select    = 8'h20;
        fan2_floor_select    = 8'h30;
        fan3_floor_select    = 8'h40;
        tgt     = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reset_check();
        ramp(3'h0, 8'h03, SLOT);
        ramp(3'h1, 8'h08, SLOT);
        ramp(3'h2, 8'h01, SLOT);
        ramp(3'h3, 8'h0A, SLOT);
        ramp(3'h7, 8'hC8, SLOT);
        apb(1'b1, 12'h040, 8'h80);
        ramp(3'h4, 8'hB4, SLOW);
        ramp(3'h5, 8'h50, SLOW);
        ramp(3'h6, 8'hF0, SLOW);
        @(posedge pclk);
        auto_m <= 3'b111;
        below  <= 3'b111;
        floor_sync(3'b001, 1'b0);
        floor_sync(3'b110, 1'b1);
        floor_sync(3'b101, 1'b1);
        fan_seen();
        floor_release(8'hF0);
        unmapped_check();
        lock_check();
        end_sim();
    end
endmodule // fdfr_core_tb
